// [logic/apsr_consts.svh]
// Purpose: Offsets, field positions, reset values and timing for the pulse shape register bank
// Assumes: 5-bit host register address, 8-bit register data
// Notes:   Definitions only
`ifndef APSR_CONSTS_SVH
`define APSR_CONSTS_SVH

`define APSR_ADDR_W        5
`define APSR_DATA_W        8
`define APSR_ADDR_SEG1     5'h08
`define APSR_ADDR_SEG2     5'h09
`define APSR_ADDR_SEG3     5'h0A
`define APSR_ADDR_SEG4     5'h0B
`define APSR_ADDR_SEG5     5'h0C
`define APSR_ADDR_SEG6     5'h0D
`define APSR_SEG_RESET     8'h00
`define APSR_SIGN_BIT      6
`define APSR_MAG_HI        5
`define APSR_AMP_HI        6
`define APSR_NUM_SEGS      8
`define APSR_NUM_REGS      6
`define APSR_SEG_IDX_W     3
`define APSR_CORE_MHZ      200
`define APSR_MCLK_KHZ      1544
`define APSR_RD_NONE       8'h00

`endif

// [logic/apsr_pkg.sv]
// Purpose: Types shared by the pulse shape register bank
// Assumes: Constants come from apsr_consts.svh
// Notes:   Types only
`include "apsr_consts.svh"
package apsr_pkg;
    typedef logic [`APSR_ADDR_W-1:0]    apsr_addr_type;
    typedef logic [`APSR_DATA_W-1:0]    apsr_data_type;
    typedef logic [`APSR_AMP_HI:0]      apsr_amp_type;
    typedef logic [`APSR_SEG_IDX_W-1:0] apsr_seg_type;
    typedef enum logic [1:0] {
        APSR_IDLE  = 2'h1,
        APSR_SHAPE = 2'h2
    } apsr_state_type;
endpackage

// [logic/apsr_seg_timer.sv]
// Purpose: Cuts each master clock period into eight segments; the eighth also takes any remainder of the period
// Assumes: mclk_tick_in is a one-cycle pulse once per master clock period
// Notes:   Segment length is measured from the previous period in core cycles
`timescale 1ns/1ps
`include "apsr_consts.svh"
module apsr_seg_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 mclk_tick_in,
    output apsr_pkg::apsr_seg_type    seg_idx_out,
    output logic                      seg_valid_out
);
    import apsr_pkg::*;

    // Elaboration-time guard: a narrower counter cannot hold eight segments of at least one cycle
    if (CNT_W < 4) begin : gen_bad_cnt_w
        $error("CNT_W too small");
    end

    logic [CNT_W-1:0] period_cnt_reg;
    logic [CNT_W-1:0] period_len_reg;
    logic [CNT_W-1:0] seg_cnt_reg;
    logic [CNT_W-1:0] seg_len;

    // One eighth of the last measured period, never shorter than one cycle
    assign seg_len = (period_len_reg >> `APSR_SEG_IDX_W) == '0 ? CNT_W'(1) : (period_len_reg >> `APSR_SEG_IDX_W);

    // Measure period length between master clock ticks
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            period_cnt_reg <= '0;
            period_len_reg <= '0;
        end else if (mclk_tick_in) begin
            period_cnt_reg <= CNT_W'(1);
            period_len_reg <= period_cnt_reg;
        end else if (period_cnt_reg != '1) begin
            period_cnt_reg <= period_cnt_reg + CNT_W'(1);
        end
    end

    // Step segments in ascending order, restarting at segment one each tick
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seg_idx_out   <= '0;
            seg_cnt_reg   <= '0;
            seg_valid_out <= 1'b0;
        end else if (mclk_tick_in) begin
            seg_idx_out   <= '0;
            seg_cnt_reg   <= CNT_W'(1);
            seg_valid_out <= period_len_reg != '0;
        end else if (seg_cnt_reg >= seg_len) begin
            seg_cnt_reg <= CNT_W'(1);
            if (seg_idx_out != apsr_seg_type'(`APSR_NUM_SEGS - 1)) begin
                seg_idx_out <= seg_idx_out + apsr_seg_type'(1);
            end
        end else begin
            seg_cnt_reg <= seg_cnt_reg + CNT_W'(1);
        end
    end
endmodule

// [logic/apsr_amp_sel.sv]
// Purpose: Picks the amplitude of the current segment
// Assumes: Segments seven and eight come from registers outside this bank
// Notes:   Registered output, one cycle after the segment index
`timescale 1ns/1ps
`include "apsr_consts.svh"
module apsr_amp_sel (
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic [`APSR_NUM_REGS*`APSR_DATA_W-1:0] regs_in,
    input  apsr_pkg::apsr_amp_type    seg_seven_in,
    input  apsr_pkg::apsr_amp_type    seg_eight_in,
    input  apsr_pkg::apsr_seg_type    seg_idx_in,
    input  wire logic                 enable_in,
    output apsr_pkg::apsr_amp_type    amp_out
);
    import apsr_pkg::*;

    apsr_amp_type amp_next;

    // Select low seven bits of the segment register; bit seven never reaches the shaper
    always_comb begin
        amp_next = '0;
        if (enable_in) begin
            if (seg_idx_in < apsr_seg_type'(`APSR_NUM_REGS)) begin
                amp_next = regs_in[seg_idx_in*`APSR_DATA_W +: (`APSR_AMP_HI+1)];
            end else if (seg_idx_in == apsr_seg_type'(`APSR_NUM_REGS)) begin
                amp_next = seg_seven_in;
            end else begin
                amp_next = seg_eight_in;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            amp_out <= '0;
        end else begin
            amp_out <= amp_next;
        end
    end
endmodule

// [logic/apsr_regs.sv]
// Purpose: Arbitrary transmit pulse shape register bank with segment sequencer
// Assumes: Host interface delivers decoded address, write strobe and data synchronous to core_clk_in
// Notes:   Six segment registers live here; segments seven and eight arrive as inputs
`timescale 1ns/1ps
`include "apsr_consts.svh"
module apsr_regs #(
    parameter int CNT_W = 16
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_n_in,
    input  apsr_pkg::apsr_addr_type   host_addr_in,
    input  wire logic                 host_wr_in,
    input  wire logic                 host_rd_in,
    input  apsr_pkg::apsr_data_type   host_wdata_in,
    output apsr_pkg::apsr_data_type   host_rdata_out,
    output logic                      host_hit_out,
    input  wire logic                 arb_mode_in,
    input  wire logic                 mclk_tick_in,
    input  apsr_pkg::apsr_amp_type    seg_seven_in,
    input  apsr_pkg::apsr_amp_type    seg_eight_in,
    output apsr_pkg::apsr_amp_type    pulse_amp_out,
    output logic                      pulse_sign_out,
    output logic                      pulse_active_out,
    output apsr_pkg::apsr_seg_type    seg_idx_out
);
    import apsr_pkg::*;

    // Elaboration-time guard: the period counter must fit a master clock period and stay a plain word
    if (CNT_W < 4 || CNT_W > 32) begin : gen_bad_cnt_w
        $error("CNT_W out of range");
    end

    logic           rst_sync1_reg;
    logic           rst_sync2_reg;
    logic           rst_n;
    apsr_data_type  seg_reg [`APSR_NUM_REGS];
    logic [`APSR_NUM_REGS*`APSR_DATA_W-1:0] seg_flat;
    logic [`APSR_NUM_REGS-1:0]  addr_hit;
    apsr_addr_type  seg_addr [`APSR_NUM_REGS];
    apsr_seg_type   seg_idx;
    logic           seg_valid;
    apsr_state_type state_reg;
    apsr_state_type state_next;
    apsr_amp_type   amp;

    // Reset released through two flops so deassertion is clean
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end
    assign rst_n = rst_sync2_reg;

    // Address table of the segment registers
    assign seg_addr[0] = `APSR_ADDR_SEG1;
    assign seg_addr[1] = `APSR_ADDR_SEG2;
    assign seg_addr[2] = `APSR_ADDR_SEG3;
    assign seg_addr[3] = `APSR_ADDR_SEG4;
    assign seg_addr[4] = `APSR_ADDR_SEG5;
    assign seg_addr[5] = `APSR_ADDR_SEG6;

    // One storage byte per segment; bit seven is kept so software reads back what it wrote
    genvar g;
    generate
        for (g = 0; g < `APSR_NUM_REGS; g++) begin : gen_seg
            assign addr_hit[g] = host_addr_in == seg_addr[g];
            assign seg_flat[g*`APSR_DATA_W +: `APSR_DATA_W] = seg_reg[g];
            always_ff @(posedge core_clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    seg_reg[g] <= `APSR_SEG_RESET;
                end else if (host_wr_in && addr_hit[g]) begin
                    seg_reg[g] <= host_wdata_in;
                end
            end
        end
    endgenerate

    // Read data registered; unmapped addresses read zero and drop the hit flag
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata_out <= `APSR_RD_NONE;
            host_hit_out   <= 1'b0;
        end else if (host_rd_in) begin
            host_hit_out <= |addr_hit;
            if (addr_hit[0]) begin
                host_rdata_out <= seg_reg[0];
            end else if (addr_hit[1]) begin
                host_rdata_out <= seg_reg[1];
            end else if (addr_hit[2]) begin
                host_rdata_out <= seg_reg[2];
            end else if (addr_hit[3]) begin
                host_rdata_out <= seg_reg[3];
            end else if (addr_hit[4]) begin
                host_rdata_out <= seg_reg[4];
            end else if (addr_hit[5]) begin
                host_rdata_out <= seg_reg[5];
            end else begin
                host_rdata_out <= `APSR_RD_NONE;
            end
        end
    end

    // Mode state: shaping starts at the next period boundary so no pulse begins mid-segment
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            APSR_IDLE: begin
                if (arb_mode_in && mclk_tick_in) begin
                    state_next = APSR_SHAPE;
                end
            end
            APSR_SHAPE: begin
                if (!arb_mode_in) begin
                    state_next = APSR_IDLE;
                end
            end
            default: begin
                state_next = APSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= APSR_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    apsr_seg_timer #(
        .CNT_W (CNT_W)
    ) u_timer (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n),
        .mclk_tick_in  (mclk_tick_in),
        .seg_idx_out   (seg_idx),
        .seg_valid_out (seg_valid)
    );

    apsr_amp_sel u_sel (
        .core_clk_in  (core_clk_in),
        .rst_n_in     (rst_n),
        .regs_in      (seg_flat),
        .seg_seven_in (seg_seven_in),
        .seg_eight_in (seg_eight_in),
        .seg_idx_in   (seg_idx),
        .enable_in    (state_reg == APSR_SHAPE && arb_mode_in && seg_valid),
        .amp_out      (amp)
    );

    // Outputs to the pulse shaper, aligned with the selected amplitude
    assign pulse_amp_out  = amp;
    assign pulse_sign_out = amp[`APSR_SIGN_BIT];

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pulse_active_out <= 1'b0;
            seg_idx_out      <= '0;
        end else begin
            pulse_active_out <= state_reg == APSR_SHAPE && arb_mode_in && seg_valid;
            seg_idx_out      <= seg_idx;
        end
    end
endmodule

// [verif/apsr_regs_asserts.sv]
// Purpose: Port-level checks for the pulse shape register bank
// Assumes: Mapped window 0x08..0x0D, one clock domain
// Notes:   Bound to apsr_regs below
`timescale 1ns/1ps
`include "apsr_consts.svh"
module apsr_regs_asserts
    import apsr_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic    core_clk_in,
    input  wire logic    rst_n_in,
    input  apsr_addr_type host_addr_in,
    input  wire logic    host_wr_in,
    input  wire logic    host_rd_in,
    input  apsr_data_type host_wdata_in,
    input  apsr_data_type host_rdata_out,
    input  wire logic    host_hit_out,
    input  wire logic    arb_mode_in,
    input  wire logic    mclk_tick_in,
    input  apsr_amp_type seg_seven_in,
    input  apsr_amp_type seg_eight_in,
    input  apsr_amp_type pulse_amp_out,
    input  wire logic    pulse_sign_out,
    input  wire logic    pulse_active_out,
    input  apsr_seg_type seg_idx_out
);
    logic map_w;
    // Address falls inside the six-register window
    assign map_w = (host_addr_in >= `APSR_ADDR_SEG1) && (host_addr_in <= `APSR_ADDR_SEG6);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // Write then read of the same place, with no write in between
    sequence wr_then_rd;
        host_wr_in && map_w ##1 host_rd_in && !host_wr_in && host_addr_in == $past(host_addr_in);
    endsequence
    sign_bit_a: assert property (pulse_sign_out == pulse_amp_out[6])
        else $error("sign output differs from amplitude bit six");
    idle_zero_a: assert property (!pulse_active_out |-> pulse_amp_out == 7'h00)
        else $error("amplitude nonzero while shaping inactive");
    mode_exit_a: assert property (!arb_mode_in [*2] |=> !pulse_active_out)
        else $error("shaping still active after mode dropped");
    seg_order_a: assert property (pulse_active_out && $past(pulse_active_out)
        && seg_idx_out != $past(seg_idx_out) |-> seg_idx_out == apsr_seg_type'($past(seg_idx_out) + 3'h1))
        else $error("segment index skipped or went backwards");
    unmapped_read_a: assert property (host_rd_in && !map_w |=> host_rdata_out == 8'h00 && !host_hit_out)
        else $error("unmapped read returned data or hit");
    mapped_hit_a: assert property (host_rd_in && map_w |=> host_hit_out)
        else $error("mapped read did not report a hit");
    rdata_hold_a: assert property (!host_rd_in |=> $stable(host_rdata_out))
        else $error("read data changed without a read");
    write_read_a: assert property (wr_then_rd |=> host_rdata_out == $past(host_wdata_in, 2))
        else $error("read back differs from byte written");
    seg_seven_a: assert property (pulse_active_out && seg_idx_out == 3'h6
        |-> pulse_amp_out == $past(seg_seven_in))
        else $error("segment seven amplitude not taken from its input");
    seg_eight_a: assert property (pulse_active_out && seg_idx_out == 3'h7
        |-> pulse_amp_out == $past(seg_eight_in))
        else $error("segment eight amplitude not taken from its input");
endmodule
bind apsr_regs apsr_regs_asserts #(.CNT_W(CNT_W)) i_apsr_regs_asserts (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .host_addr_in(host_addr_in), .host_wr_in(host_wr_in),
    .host_rd_in(host_rd_in), .host_wdata_in(host_wdata_in), .host_rdata_out(host_rdata_out),
    .host_hit_out(host_hit_out), .arb_mode_in(arb_mode_in), .mclk_tick_in(mclk_tick_in),
    .seg_seven_in(seg_seven_in), .seg_eight_in(seg_eight_in), .pulse_amp_out(pulse_amp_out),
    .pulse_sign_out(pulse_sign_out), .pulse_active_out(pulse_active_out), .seg_idx_out(seg_idx_out));

// [verif/apsr_tb.sv]
// Purpose: Self-checking bench for the pulse shape register bank
// Assumes: Master clock tick every 80 core cycles, so segments are 10 cycles
// Notes:   Inputs change at the falling edge
`timescale 1ns/1ps
module testbench;
    import apsr_pkg::*;
    logic          core_clk_in, rst_n_in, host_wr_in, host_rd_in, arb_mode_in, mclk_tick_in;
    logic          host_hit_out, pulse_sign_out, pulse_active_out;
    apsr_addr_type host_addr_in;
    apsr_data_type host_wdata_in, host_rdata_out;
    apsr_amp_type  seg_seven_in, seg_eight_in, pulse_amp_out;
    apsr_seg_type  seg_idx_out;
    int            mismatches = 0, tests_run = 0, cyc = 0;
    apsr_data_type vals [6] = '{8'hC5, 8'h3A, 8'h7F, 8'h80, 8'h41, 8'h0E};
    apsr_regs #(.CNT_W(16)) i_apsr_regs (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .host_addr_in(host_addr_in), .host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
        .host_wdata_in(host_wdata_in), .host_rdata_out(host_rdata_out), .host_hit_out(host_hit_out),
        .arb_mode_in(arb_mode_in), .mclk_tick_in(mclk_tick_in), .seg_seven_in(seg_seven_in),
        .seg_eight_in(seg_eight_in), .pulse_amp_out(pulse_amp_out), .pulse_sign_out(pulse_sign_out),
        .pulse_active_out(pulse_active_out), .seg_idx_out(seg_idx_out));
    // 200 MHz core clock
    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    // Master clock tick and a hang guard well above the expected run
    always @(negedge core_clk_in) begin
        cyc <= cyc + 1;
        mclk_tick_in <= (cyc % 80 == 79);
        if (cyc == 5000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk_data(input apsr_data_type got, input apsr_data_type exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic wr(input apsr_addr_type a, input apsr_data_type d);
        host_addr_in = a;
        host_wdata_in = d;
        host_wr_in = 1'b1;
        @(negedge core_clk_in);
        host_wr_in = 1'b0;
    endtask
    // Strobe for one edge; the registered answer is settled by the next falling edge
    task automatic rd(input apsr_addr_type a, input apsr_data_type exp, input logic hit);
        host_addr_in = a;
        host_rd_in = 1'b1;
        @(negedge core_clk_in);
        host_rd_in = 1'b0;
        chk_data(host_rdata_out, exp, "read data");
        chk_bit(host_hit_out, hit, "read hit");
        // Idle edge so a following read never lowers and raises the strobe in one step
        @(negedge core_clk_in);
    endtask
    task automatic t_reset_values();
        for (int i = 0; i < 6; i++) rd(5'(8 + i), 8'h00, 1'b1);
    endtask
    // Back-to-back write and read, bit seven included
    task automatic t_readback();
        for (int i = 0; i < 6; i++) begin
            wr(5'(8 + i), vals[i]);
            rd(5'(8 + i), vals[i], 1'b1);
        end
    endtask
    task automatic t_unmapped();
        wr(5'h07, 8'hFF);
        @(negedge core_clk_in);
        wr(5'h0E, 8'hFF);
        rd(5'h07, 8'h00, 1'b0);
        rd(5'h1F, 8'h00, 1'b0);
        rd(5'h0B, vals[3], 1'b1);
    endtask
    // One whole period: each segment shown for an eighth, with its own amplitude
    task automatic t_shape();
        int cnt [8];
        apsr_amp_type exp;
        cnt = '{default: 0};
        arb_mode_in = 1'b1;
        repeat (320) @(negedge core_clk_in);
        chk_bit(pulse_active_out, 1'b1, "shaping active");
        repeat (80) begin
            cnt[seg_idx_out]++;
            exp = (seg_idx_out < 6) ? vals[seg_idx_out][6:0] : (seg_idx_out == 6) ? seg_seven_in : seg_eight_in;
            chk_data({1'b0, pulse_amp_out}, {1'b0, exp}, "segment amplitude");
            chk_bit(pulse_sign_out, exp[6], "segment sign");
            @(negedge core_clk_in);
        end
        for (int k = 0; k < 8; k++) chk_data(8'(cnt[k]), 8'h0A, "segment length");
    endtask
    task automatic t_mode_off();
        arb_mode_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
        repeat (80) begin
            chk_bit(pulse_active_out, 1'b0, "shaping idle");
            chk_data({1'b0, pulse_amp_out}, 8'h00, "idle amplitude");
            @(negedge core_clk_in);
        end
    endtask
    initial begin
        rst_n_in = 1'b0;
        host_wr_in = 1'b0;
        host_rd_in = 1'b0;
        host_addr_in = 5'h00;
        host_wdata_in = 8'h00;
        arb_mode_in = 1'b0;
        seg_seven_in = 7'h11;
        seg_eight_in = 7'h52;
        repeat (2) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        t_reset_values();
        t_readback();
        t_unmapped();
        t_shape();
        t_mode_off();
        complete_run();
    end
endmodule
